// ==== logic/pfd_pkg.sv ====
// Package: constants and carrier types for the phase frequency detector
package pfd_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int OVERLAP_TIME_NS = 15;
  // Least time, rounded up to whole cycles, never below one
  localparam int OVERLAP_CYCLES_RAW =
    (OVERLAP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int OVERLAP_CYCLES =
    (OVERLAP_CYCLES_RAW < 1) ? 1 : OVERLAP_CYCLES_RAW;
  localparam int OVL_CNT_W = 8;
  // Reset values
  localparam logic UP_RESET = 1'b0;
  localparam logic DOWN_RESET = 1'b0;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic up;
    logic down;
  } pfd_pump_t;
  typedef enum logic [1:0] {
    PFD_IDLE,
    PFD_UP,
    PFD_DOWN,
    PFD_OVERLAP
  } pfd_state_t;
endpackage : pfd_pkg

// ==== logic/pfd_edge_det.sv ====
// Rising edge detector for one synchronous input
`timescale 1ns/10ps
`default_nettype none
module pfd_edge_det (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic level_in,
  output logic rise
);
  logic prev;
  // Only rising transitions matter, so duty cycle is ignored
  assign rise = enable & level_in & ~prev;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev <= 1'b0;
    end else begin
      prev <= level_in;
    end
  end
endmodule : pfd_edge_det
`default_nettype wire

// ==== logic/pfd_top.sv ====
// Phase frequency detector: xor and edge comparators with charge pump
`timescale 1ns/10ps
`default_nettype none
module pfd_top
#(
  parameter int OVERLAP_LEN = pfd_pkg::OVERLAP_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reference_input,
  input wire logic feedback_input,
  input wire logic bias_sense_pin,
  input wire logic power_down_input,
  output logic xor_detector_output,
  output pfd_pkg::pfd_pump_t charge_pump_drive,
  output logic charge_pump_oe_n,
  output logic lock_pulse_output
);
  import pfd_pkg::*;

  // ----------------------------------------------------------------
  // Parameter limits
  // ----------------------------------------------------------------
  // Counter width caps the overlap; zero would wrap the compare to 255 and stretch the overlap to 256 cycles
  if (OVERLAP_LEN < 1 || OVERLAP_LEN >= (1 << OVL_CNT_W)) begin : g_bad_len
    $error("OVERLAP_LEN out of range");
  end

  // ----------------------------------------------------------------
  // Input edges
  // ----------------------------------------------------------------
  logic run;
  logic ref_rise;
  logic fb_rise;
  assign run = ~power_down_input;

  pfd_edge_det u_ref_edge (
    .core_clk(core_clk),
    .rst(rst),
    .enable(run),
    .level_in(reference_input),
    .rise(ref_rise)
  );

  pfd_edge_det u_fb_edge (
    .core_clk(core_clk),
    .rst(rst),
    .enable(run),
    .level_in(feedback_input),
    .rise(fb_rise)
  );

  // ----------------------------------------------------------------
  // Edge comparator flip-flops
  // ----------------------------------------------------------------
  logic up_ff;
  logic down_ff;
  logic [OVL_CNT_W-1:0] ovl_cnt;
  logic ovl_done;
  logic both_set;
  logic next_up;
  logic next_down;
  logic [OVL_CNT_W-1:0] next_ovl_cnt;
  pfd_state_t state;

  assign both_set = up_ff & down_ff;
  assign ovl_done = both_set &&
    (ovl_cnt == OVL_CNT_W'(OVERLAP_LEN - 1));
  // Each flop sets on its edge; the overlap gate clears both together.
  // A new edge landing in the clearing cycle restarts that side.
  assign next_up = run & ((up_ff & ~ovl_done) | ref_rise);
  assign next_down = run & ((down_ff & ~ovl_done) | fb_rise);
  assign next_ovl_cnt = (both_set && !ovl_done) ?
    OVL_CNT_W'(ovl_cnt + 1'b1) : '0;

  always_comb begin
    case ({up_ff, down_ff})
      2'b10: state = PFD_UP;
      2'b01: state = PFD_DOWN;
      2'b11: state = PFD_OVERLAP;
      default: state = PFD_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      up_ff <= UP_RESET;
      down_ff <= DOWN_RESET;
      ovl_cnt <= '0;
    end else begin
      up_ff <= next_up;
      down_ff <= next_down;
      ovl_cnt <= next_ovl_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic xor_now;
  logic lock_now;
  logic next_shared;
  logic next_oe_n;
  assign xor_now = run & (reference_input ^ feedback_input);
  assign lock_now = run & (state != PFD_IDLE);
  assign next_shared = bias_sense_pin ? lock_now : xor_now;
  // Pump floats whenever neither driver is on
  assign next_oe_n = ~lock_now;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      xor_detector_output <= 1'b0;
      lock_pulse_output <= 1'b0;
      charge_pump_drive <= '0;
      charge_pump_oe_n <= 1'b1;
    end else begin
      xor_detector_output <= next_shared;
      lock_pulse_output <= lock_now;
      charge_pump_drive.up <= run & up_ff;
      charge_pump_drive.down <= run & down_ff;
      charge_pump_oe_n <= next_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  overlap_length_a: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(both_set) && run |-> both_set [*3] ##1 !both_set)
    else $error("overlap not three cycles");

  overlap_clear_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ovl_done && !ref_rise && !fb_rise |=> !up_ff && !down_ff)
    else $error("overlap did not clear flops");

  ref_up_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ref_rise |=> up_ff)
    else $error("reference edge did not set up");

  fb_down_a: assert property (
    @(posedge core_clk) disable iff (rst)
    fb_rise |=> down_ff)
    else $error("feedback edge did not set down");

  up_hold_a: assert property (
    @(posedge core_clk) disable iff (rst)
    up_ff && !down_ff && !fb_rise && run |=> up_ff)
    else $error("up dropped without feedback edge");

  pump_follow_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ##1 charge_pump_drive.up == $past(run & up_ff) &&
      charge_pump_drive.down == $past(run & down_ff))
    else $error("pump drive mismatch");

  pump_float_a: assert property (
    @(posedge core_clk) disable iff (rst)
    charge_pump_oe_n ==
      !(charge_pump_drive.up | charge_pump_drive.down))
    else $error("pump enable mismatch");

  pump_drive_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (up_ff | down_ff) && run |=> !charge_pump_oe_n)
    else $error("pump floats while driven");

  lock_follow_a: assert property (
    @(posedge core_clk) disable iff (rst)
    lock_pulse_output ==
      (charge_pump_drive.up | charge_pump_drive.down))
    else $error("lock pulse not drive union");

  up_only_a: assert property (
    @(posedge core_clk) disable iff (rst)
    up_ff && !down_ff && run |=>
      charge_pump_drive.up && !charge_pump_drive.down)
    else $error("source driver not alone");

  down_only_a: assert property (
    @(posedge core_clk) disable iff (rst)
    down_ff && !up_ff && run |=>
      charge_pump_drive.down && !charge_pump_drive.up)
    else $error("sink driver not alone");

  no_dead_zone_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ref_rise && !fb_rise && !down_ff && !up_ff |=> up_ff && !down_ff)
    else $error("single edge gave no pulse");

  both_pump_a: assert property (
    @(posedge core_clk) disable iff (rst)
    both_set && run |=> charge_pump_drive.up && charge_pump_drive.down)
    else $error("overlap not on both drivers");

  overlap_bound_a: assert property (
    @(posedge core_clk) disable iff (rst)
    both_set |-> ovl_cnt < OVL_CNT_W'(OVERLAP_LEN))
    else $error("overlap counter overran");

  count_idle_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !both_set |=> ovl_cnt == '0)
    else $error("overlap counter not cleared");

  pd_clear_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !run |=> !up_ff && !down_ff)
    else $error("flops set in power down");

  shared_pin_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !bias_sense_pin && run |=> xor_detector_output ==
      ($past(reference_input) ^ $past(feedback_input)))
    else $error("shared pin not xor");

  lock_share_a: assert property (
    @(posedge core_clk) disable iff (rst)
    bias_sense_pin |=> xor_detector_output == lock_pulse_output)
    else $error("shared pin not lock pulse");

  power_down_a: assert property (
    @(posedge core_clk) disable iff (rst)
    power_down_input [*2] |=> !xor_detector_output &&
      charge_pump_oe_n && !lock_pulse_output)
    else $error("outputs active in power down");

  down_hold_a: assert property (
    @(posedge core_clk) disable iff (rst)
    down_ff && !up_ff && !ref_rise && run |=> down_ff)
    else $error("down dropped without reference edge");
endmodule : pfd_top
`default_nettype wire

// ==== test/pfd_fb_model.sv ====
// Square-wave source standing for the divided oscillator feedback
`timescale 1ns/10ps
`default_nettype none
module pfd_fb_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic en,
  input wire logic [7:0] half,
  output logic feedback
);
  logic [7:0] cnt;
  // Equal high and low spans keep the duty at one half
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
      feedback <= 1'b0;
    end else if (!en) begin
      cnt <= 8'h00;
      feedback <= 1'b0;
    end else if (cnt == 8'h00) begin
      cnt <= half - 8'h01;
      feedback <= !feedback;
    end else begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule : pfd_fb_model
`default_nettype wire

// ==== test/testbench.sv ====
// Testbench: both comparators fed by two square-wave sources
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: mismatch", $time); end end
module testbench;
  import pfd_pkg::*;
  localparam int OVL = 3;
  logic core_clk = 1'b0, rst = 1'b1, bias = 1'b0, pd = 1'b0;
  logic r_en = 1'b0, f_en = 1'b0, ref_in, fb_in, x_out, oe_n, lock;
  logic p_x = 1'b0, p_b = 1'b0, p_pd = 1'b0, cnt_en = 1'b0;
  logic [7:0] r_half = 8'h14, f_half = 8'h14;
  pfd_pump_t pump;
  int mismatches = 0, n_checks = 0, n_up, n_dn, n_both, n_lock, d;
  pfd_fb_model ref_src (.core_clk(core_clk), .rst(rst), .en(r_en),
    .half(r_half), .feedback(ref_in));
  pfd_fb_model fb_src (.core_clk(core_clk), .rst(rst), .en(f_en),
    .half(f_half), .feedback(fb_in));
  pfd_top #(.OVERLAP_LEN(OVL)) dut (.core_clk(core_clk), .rst(rst),
    .reference_input(ref_in), .feedback_input(fb_in),
    .bias_sense_pin(bias), .power_down_input(pd),
    .xor_detector_output(x_out), .charge_pump_drive(pump),
    .charge_pump_oe_n(oe_n), .lock_pulse_output(lock));
  initial forever #2 core_clk = ~core_clk;
  function automatic int per4(input int v);
    return v > 0 ? 4 * v : 0;
  endfunction : per4
  // Sampled mid-cycle, away from the launching edge
  always @(negedge core_clk) begin
    if (!rst) begin
      `CHK(x_out, p_pd ? 1'b0 : (p_b ? lock : p_x))
      `CHK(oe_n, !(pump.up | pump.down))
      `CHK(lock, pump.up | pump.down)
      if (p_pd) `CHK(pump, 2'h0)
      if (cnt_en) begin
        n_up += int'(pump.up & !pump.down);
        n_dn += int'(pump.down & !pump.up);
        n_both += int'(pump.up & pump.down);
        n_lock += int'(lock);
      end
    end
    p_x <= ref_in ^ fb_in;
    p_b <= bias;
    p_pd <= pd;
  end
  // Window starts mid-period so no pulse is cut in two
  task automatic run(input logic [7:0] hr, hf, input int dd, n);
    r_half <= hr;
    f_half <= hf;
    bias <= 1'($urandom);
    if (dd <= 0) f_en <= 1'b1;
    if (dd >= 0) r_en <= 1'b1;
    repeat (dd < 0 ? -dd : dd) @(posedge core_clk);
    if (dd > 0) f_en <= 1'b1;
    if (dd < 0) r_en <= 1'b1;
    repeat (3 * hr - (dd > 0 ? dd : 0)) @(posedge core_clk);
    n_up = 0;
    n_dn = 0;
    n_both = 0;
    n_lock = 0;
    cnt_en <= 1'b1;
    repeat (2 * hr * n) @(posedge core_clk);
    cnt_en <= 1'b0;
    r_en <= 1'b0;
    f_en <= 1'b0;
    pd <= 1'b1;
    repeat (3) @(posedge core_clk);
    pd <= 1'b0;
  endtask : run
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    #200000;
    mismatches++;
    give_verdict;
  end
  initial begin
    void'($urandom(61130));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 12; i++) begin
      d = (i < 3) ? i - 1 : int'($urandom_range(16)) - 8;
      run(8'h14, 8'h14, d, 4);
      `CHK(n_up, per4(d))
      `CHK(n_dn, per4(-d))
      `CHK(n_both, 4 * OVL)
      `CHK(n_lock, per4(d) + per4(-d) + 4 * OVL)
    end
    run(8'h05, 8'h0F, 0, 6);
    `CHK(n_up > n_dn, 1'b1)
    run(8'h0F, 8'h05, 0, 6);
    `CHK(n_dn > n_up, 1'b1)
    n_up = 0;
    n_dn = 0;
    f_en <= 1'b1;
    cnt_en <= 1'b1;
    repeat (80) @(posedge core_clk);
    cnt_en <= 1'b0;
    `CHK(n_up, 0)
    `CHK(n_dn > 60, 1'b1)
    give_verdict;
  end
endmodule : testbench
`default_nettype wire
